// ### pkg/swire_host_pkg.sv
package swire_host_pkg;
	// clock
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_US = 1000;
	localparam int US_CYCLES = NS_PER_US / CLK_PERIOD_NS;

	// bus timing, microseconds
	localparam int RESET_LOW_TIME_US = 480;
	localparam int RESET_RECOVERY_TIME_US = 470;
	localparam int RESET_TOTAL_LIMIT_US = 960;
	localparam int PRESENCE_SAMPLE_US = 70;
	localparam int LINE_LOW_LIMIT_US = 120;
	localparam int WRITE0_LOW_US = 60;
	localparam int WRITE1_LOW_US = 6;
	localparam int READ_LOW_US = 1;
	localparam int READ_SAMPLE_US = 13;
	localparam int READ_VALID_WINDOW_US = 15;
	localparam int SLOT_END_US = 70;
	localparam int US_W = 10;

	// APB register map
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
	localparam logic [ADDR_W-1:0] DATA_OFFSET = 12'h004;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h008;
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_OP_W = 3;
	localparam int CTRL_DIR_BIT = 3;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_PRESENCE_BIT = 1;
	localparam int STAT_ID_BIT = 2;
	localparam int STAT_CMP_BIT = 3;
	localparam int STAT_TAKEN_BIT = 4;

	// operations started by a write to the control register
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_RESET = 3'h1;
	localparam logic [2:0] OP_WRITE_BIT = 3'h2;
	localparam logic [2:0] OP_READ_BIT = 3'h3;
	localparam logic [2:0] OP_WRITE_BYTE = 3'h4;
	localparam logic [2:0] OP_READ_BYTE = 3'h5;
	localparam logic [2:0] OP_TRIPLET = 3'h6;
	localparam logic [3:0] SLOTS_BIT = 4'h1;
	localparam logic [3:0] SLOTS_BYTE = 4'h8;
	localparam logic [3:0] SLOTS_TRIPLET = 4'h3;
	localparam logic [3:0] TRIPLET_WRITE_SLOT = 4'h2;

	// map of the device outside, reached by byte commands over the line
	localparam logic [7:0] COND_SEARCH_CMD = 8'hEC;
	localparam logic [7:0] SEARCH_CONDITION_SELECT = 8'h07;
	localparam int SEARCH_POLARITY_BIT = 0;
	localparam int SOURCE_SELECT_LOW = 1;
	localparam int SOURCE_SELECT_HIGH = 2;
	localparam int CHANNEL_SELECT_LOW = 3;
	localparam int CHANNEL_SELECT_HIGH = 4;
	localparam logic [4:0] SEARCH_CONDITION_POWERUP = 5'h1F;

	typedef enum {ST_IDLE, ST_RST_LOW, ST_RST_REL, ST_SLOT} host_state_e;
endpackage

// ### rtl/swire_search_host.sv
module swire_search_host
	import swire_host_pkg::*;
#(
	parameter logic [US_W-1:0] RESET_LOW_US = US_W'(RESET_LOW_TIME_US),
	parameter logic [US_W-1:0] RESET_RECOVERY_US = US_W'(RESET_RECOVERY_TIME_US)
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic DQ_IN,
	output logic DQ_OUT,
	output logic DQ_OE_N
);
	localparam logic [US_W-1:0] US_ONE = US_W'(1);
	host_state_e state, next_state;
	logic [2:0] op, next_op;
	logic [3:0] slot_num, next_slot_num;
	logic [3:0] slot_total, next_slot_total;
	logic [US_W-1:0] elapsed, next_elapsed;
	logic [7:0] shift, next_shift;
	logic dir, next_dir;
	logic id_bit, next_id_bit;
	logic cmp_bit, next_cmp_bit;
	logic taken, next_taken;
	logic presence, next_presence;
	logic drive, next_drive;
	logic [31:0] rdata, next_rdata;
	logic tick, tick_clr, sample, slot_begin;
	logic wr_access, start, mapped;
	////////////////////////////////////////////////////////////////////////
	us_tick #(.DIV(US_CYCLES)) us_tick_i (
		.clk(CLK),
		.rst(SYS_RST),
		.clr(tick_clr),
		.tick(tick)
	);
	function automatic logic slot_is_read(input logic [2:0] o, input logic [3:0] s);
		slot_is_read = (o == OP_READ_BIT) || (o == OP_READ_BYTE) ||
			(o == OP_TRIPLET && s < TRIPLET_WRITE_SLOT);
	endfunction
	function automatic logic [US_W-1:0] low_len(input logic [2:0] o, input logic [3:0] s,
			input logic t, input logic b0);
		logic wv;
		wv = (o == OP_TRIPLET) ? t : b0;
		if (slot_is_read(o, s)) begin
			low_len = US_W'(READ_LOW_US);
		end else if (wv) begin
			low_len = US_W'(WRITE1_LOW_US);
		end else begin
			low_len = US_W'(WRITE0_LOW_US);
		end
	endfunction
	////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, read data latched in the setup cycle
	always_comb begin
		mapped = (PADDR == CTRL_OFFSET) || (PADDR == DATA_OFFSET) ||
			(PADDR == STATUS_OFFSET);
		wr_access = PSEL && PENABLE && PWRITE;
		// commands arriving while busy are dropped; software polls busy first
		start = wr_access && (PADDR == CTRL_OFFSET) && (state == ST_IDLE);
		next_rdata = rdata;
		if (PSEL && !PENABLE) begin
			next_rdata = '0;
			case (PADDR)
				CTRL_OFFSET: next_rdata[CTRL_DIR_BIT] = dir;
				DATA_OFFSET: next_rdata[7:0] = shift;
				STATUS_OFFSET: begin
					next_rdata[STAT_BUSY_BIT] = (state != ST_IDLE);
					next_rdata[STAT_PRESENCE_BIT] = presence;
					next_rdata[STAT_ID_BIT] = id_bit;
					next_rdata[STAT_CMP_BIT] = cmp_bit;
					next_rdata[STAT_TAKEN_BIT] = taken;
				end
				default: next_rdata = '0;
			endcase
		end
	end
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped;
	assign PRDATA = rdata;
	////////////////////////////////////////////////////////////////////////
	// line sequencer
	always_comb begin
		next_state = state;
		next_op = op;
		next_slot_num = slot_num;
		next_slot_total = slot_total;
		next_elapsed = elapsed;
		next_shift = shift;
		next_dir = dir;
		next_id_bit = id_bit;
		next_cmp_bit = cmp_bit;
		next_taken = taken;
		next_presence = presence;
		tick_clr = 1'b0;
		sample = 1'b0;
		if (state == ST_IDLE && wr_access) begin
			if (PADDR == CTRL_OFFSET) begin
				next_dir = PWDATA[CTRL_DIR_BIT];
			end else if (PADDR == DATA_OFFSET) begin
				next_shift = PWDATA[7:0];
			end
		end
		case (state)
			ST_IDLE: begin
				if (start) begin
					next_op = PWDATA[CTRL_OP_LSB +: CTRL_OP_W];
					next_slot_num = '0;
					next_elapsed = '0;
					tick_clr = 1'b1;
					next_state = ST_SLOT;
					case (PWDATA[CTRL_OP_LSB +: CTRL_OP_W])
						OP_RESET: begin
							next_state = ST_RST_LOW;
							next_presence = 1'b0;
						end
						OP_WRITE_BIT, OP_READ_BIT: next_slot_total = SLOTS_BIT;
						OP_WRITE_BYTE, OP_READ_BYTE: next_slot_total = SLOTS_BYTE;
						OP_TRIPLET: next_slot_total = SLOTS_TRIPLET;
						default: begin
							next_state = ST_IDLE;
							tick_clr = 1'b0;
						end
					endcase
				end
			end
			ST_RST_LOW: begin
				if (tick) begin
					next_elapsed = elapsed + US_ONE;
					if (elapsed == RESET_LOW_US - US_ONE) begin
						next_state = ST_RST_REL;
						next_elapsed = '0;
					end
				end
			end
			ST_RST_REL: begin
				if (tick) begin
					next_elapsed = elapsed + US_ONE;
					// the presence pulse is sure to be low at 70 us after release
					if (elapsed == US_W'(PRESENCE_SAMPLE_US - 1)) begin
						next_presence = !DQ_IN;
					end
					if (elapsed == RESET_RECOVERY_US - US_ONE) begin
						next_state = ST_IDLE;
					end
				end
			end
			ST_SLOT: begin
				if (tick) begin
					next_elapsed = elapsed + US_ONE;
					if (slot_is_read(op, slot_num) &&
							elapsed == US_W'(READ_SAMPLE_US - 1)) begin
						sample = 1'b1;
						if (op == OP_READ_BYTE) begin
							next_shift = {DQ_IN, shift[7:1]};
						end else if (op == OP_READ_BIT) begin
							next_shift = {7'h00, DQ_IN};
						end else if (slot_num == 4'h0) begin
							next_id_bit = DQ_IN;
						end else begin
							// both zero means a conflict: follow software's direction
							next_cmp_bit = DQ_IN;
							next_taken = (id_bit != DQ_IN) ? id_bit : dir;
						end
					end
					if (elapsed == US_W'(SLOT_END_US - 1)) begin
						if (op == OP_WRITE_BYTE) begin
							next_shift = {1'b0, shift[7:1]};
						end
						next_slot_num = slot_num + 4'h1;
						next_elapsed = '0;
						if (slot_num + 4'h1 == slot_total) begin
							next_state = ST_IDLE;
						end else begin
							tick_clr = 1'b1;
						end
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
		next_drive = (next_state == ST_RST_LOW) || (next_state == ST_SLOT &&
			next_elapsed < low_len(next_op, next_slot_num, next_taken, next_shift[0]));
		slot_begin = tick_clr && (next_state == ST_SLOT);
	end
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state <= ST_IDLE;
			op <= OP_NONE;
			slot_num <= '0;
			slot_total <= '0;
			elapsed <= '0;
			shift <= '0;
			dir <= 1'b0;
			id_bit <= 1'b0;
			cmp_bit <= 1'b0;
			taken <= 1'b0;
			presence <= 1'b0;
			drive <= 1'b0;
			rdata <= '0;
		end else begin
			state <= next_state;
			op <= next_op;
			slot_num <= next_slot_num;
			slot_total <= next_slot_total;
			elapsed <= next_elapsed;
			shift <= next_shift;
			dir <= next_dir;
			id_bit <= next_id_bit;
			cmp_bit <= next_cmp_bit;
			taken <= next_taken;
			presence <= next_presence;
			drive <= next_drive;
			rdata <= next_rdata;
		end
	end
	// open drain: the line is only ever pulled low, never driven high
	assign DQ_OUT = 1'b0;
	assign DQ_OE_N = !drive;
	////////////////////////////////////////////////////////////////////////
	// helper counters for the timing checks
	logic [16:0] low_cycles;
	logic [17:0] rst_cycles;
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			low_cycles <= '0;
			rst_cycles <= '0;
		end else begin
			low_cycles <= drive ? low_cycles + 17'h00001 : '0;
			rst_cycles <= (state == ST_RST_LOW || state == ST_RST_REL) ?
				rst_cycles + 18'h00001 : '0;
		end
	end
	sequence slot_opened;
		slot_begin ##1 !DQ_OE_N;
	endsequence
	AST_DRIVE_OWN: assert property (@(posedge CLK) disable iff (SYS_RST)
		!DQ_OE_N |-> (state == ST_RST_LOW || state == ST_SLOT))
		else $error("line pulled low outside reset or slot");
	AST_RESET_MIN_LOW: assert property (@(posedge CLK) disable iff (SYS_RST)
		$rose(DQ_OE_N) && state == ST_RST_REL |->
			$past(low_cycles) >= 17'(int'(RESET_LOW_US) * US_CYCLES - 1))
		else $error("reset pulse shorter than minimum");
	AST_RESET_TOTAL: assert property (@(posedge CLK) disable iff (SYS_RST)
		rst_cycles < 18'(RESET_TOTAL_LIMIT_US * US_CYCLES))
		else $error("reset plus recovery too long");
	AST_SLOT_LOW_LIMIT: assert property (@(posedge CLK) disable iff (SYS_RST)
		state == ST_SLOT |-> low_cycles < 17'(LINE_LOW_LIMIT_US * US_CYCLES))
		else $error("slot held line low too long");
	AST_SLOT_OPENS_LOW: assert property (@(posedge CLK) disable iff (SYS_RST)
		slot_begin |-> slot_opened)
		else $error("slot not opened by a low level");
	AST_READ_SAMPLE: assert property (@(posedge CLK) disable iff (SYS_RST)
		sample |-> DQ_OE_N && elapsed == US_W'(READ_SAMPLE_US - 1) &&
			elapsed < US_W'(READ_VALID_WINDOW_US))
		else $error("read sample outside valid window");
	AST_TRIPLET_ORDER: assert property (@(posedge CLK) disable iff (SYS_RST)
		state == ST_SLOT && op == OP_TRIPLET && elapsed == US_W'(WRITE1_LOW_US) |->
			(slot_num < TRIPLET_WRITE_SLOT) ? DQ_OE_N : (DQ_OE_N == taken))
		else $error("search step order or chosen bit wrong");
	AST_WRITE_ONE_SHORT: assert property (@(posedge CLK) disable iff (SYS_RST)
		slot_begin && (next_op == OP_WRITE_BIT || next_op == OP_WRITE_BYTE) && next_shift[0] |->
			##1 (!DQ_OE_N) [*2] ##[1:700] DQ_OE_N)
		else $error("write-one slot not released early");
endmodule

// ### rtl/us_tick.sv
module us_tick
	import swire_host_pkg::*;
#(
	parameter int DIV = US_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clr,
	output logic tick
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] ONE = CW'(1);

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;

	// clearing restarts the phase so that every interval is a full microsecond
	always_comb begin
		if (clr || cnt == LAST) begin
			next_cnt = '0;
		end else begin
			next_cnt = cnt + ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	// tick must not look at clr: the sequencer raises clr from tick, which would loop
	assign tick = (cnt == LAST);
endmodule

// ### verif/swire_device_model.sv
module swire_device_model
	import swire_host_pkg::*;
#(
	parameter logic [63:0] ROM_CODE = 64'h0000_1357_9BDF_00A5, // arbitrary value
	parameter logic [1:0] FF_Q = 2'h3,
	parameter logic HAS_B = 1'b1,
	parameter realtime RST_DET_NS = 80000.0
) (
	input wire logic line,
	input wire logic pin_a,
	input wire logic pin_b,
	output logic oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////////////////
	localparam realtime WAIT_NS = 30000.0;
	localparam realtime PDL_NS = 60000.0;
	localparam realtime HOLD_NS = 30000.0;
	logic [4:0] cond = SEARCH_CONDITION_POWERUP;
	logic [1:0] act = 2'h0;
	logic [7:0] cmd;
	logic [5:0] idx;
	logic active = 1'b0;
	logic bit_in;
	int nbits = 8;
	int step;
	realtime t0;

	initial oe_n = 1'b1;
	always @(posedge pin_a or negedge pin_a) act[0] = 1'b1;
	always @(posedge pin_b or negedge pin_b) act[1] = HAS_B | act[1];

	function automatic logic qualifies(input logic [4:0] c);
		logic [1:0] v;
		case (c[SOURCE_SELECT_HIGH:SOURCE_SELECT_LOW])
			2'h1: v = act;
			2'h2: v = FF_Q;
			default: v = {pin_b, pin_a};
		endcase
		v = v & {HAS_B, 1'b1};
		if (c[2:1] == 2'h0 || c[4:3] == 2'h0)
			return !c[SEARCH_POLARITY_BIT];
		return (|(v & c[4:3])) == c[SEARCH_POLARITY_BIT];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// the slot kind is fixed at the falling edge, the reset is only known at the rise
	always begin
		@(negedge line);
		t0 = $realtime;
		if (active && step < 2 && (ROM_CODE[idx] ^ step[0]) == 1'b0) begin
			oe_n = 1'b0;
			#(HOLD_NS) oe_n = 1'b1;
		end else if (!active || step == 2)
			#(HOLD_NS) bit_in = line;
		wait (line === 1'b1);
		if ($realtime - t0 > RST_DET_NS) begin
			#(WAIT_NS) oe_n = 1'b0;
			#(PDL_NS) oe_n = 1'b1;
			nbits = 0;
			active = 1'b0;
		end else if (nbits < 8) begin
			cmd = {bit_in, cmd[7:1]};
			nbits++;
			idx = 6'h00;
			step = 0;
			if (nbits == 8)
				active = (cmd == COND_SEARCH_CMD) ? qualifies(cond) : (cmd == 8'hF0);
		end else if (active) begin
			if (step == 2 && bit_in != ROM_CODE[idx])
				active = 1'b0;
			idx = (step == 2) ? idx + 6'h01 : idx;
			step = (step == 2) ? 0 : step + 1;
		end
	end
endmodule

// ### verif/swire_search_host_tb.sv
module swire_search_host_tb
	import swire_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// reset low must exceed the longest slot low so the model can tell them apart
	localparam logic [US_W-1:0] RST_US = 10'h046;
	localparam logic [US_W-1:0] REC_US = 10'h064;
	localparam logic [63:0] ROM = 64'h0000_2468_ACE0_0035; // arbitrary value
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, dq_oe_n, dev_oe_n, dq_out;
	logic pin_a = 1'b0;
	logic [31:0] rd;
	logic er;
	wire line;
	int error_cnt = 0;
	int checks_done = 0;
	int run = 0;
	int last_run = 0;

	assign line = dq_oe_n & dev_oe_n;
	initial forever #5 clk = ~clk;

	swire_search_host #(.RESET_LOW_US(RST_US), .RESET_RECOVERY_US(REC_US)) swire_search_host_i (
		.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.DQ_IN(line), .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n));
	// reset detection sits between the 60 us write-zero low and the 70 us reset low
	swire_device_model #(.ROM_CODE(ROM), .RST_DET_NS(65000.0)) swire_device_model_i (
		.line(line), .pin_a(pin_a), .pin_b(1'b0), .oe_n(dev_oe_n));

	// length of the last low pulse the host drove
	always @(posedge clk) begin
		if (dq_oe_n === 1'b0)
			run <= run + 1;
		else begin
			if (run > 0)
				last_run <= run;
			run <= 0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 50) begin
			error_cnt++;
			results();
		end
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 20000; i++) begin
			apb(1'b0, STATUS_OFFSET, 32'h0);
			if (rd[STAT_BUSY_BIT] === 1'b0)
				return;
		end
		error_cnt++;
		results();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		check("idle line", dq_oe_n, 32'h1);
		check("drive level", dq_out, 32'h0);
		apb(1'b0, 12'h00C, 32'h0);
		check("unmapped error", er, 32'h1);
		check("unmapped data", rd, 32'h0);
		pin_a <= 1'b1;
		apb(1'b1, CTRL_OFFSET, 32'(OP_RESET));
		wait_idle();
		check("reset low cycles", last_run, RST_US * US_CYCLES);
		check("presence", rd[STAT_PRESENCE_BIT], 32'h1);
		apb(1'b1, DATA_OFFSET, 32'(COND_SEARCH_CMD));
		apb(1'b1, CTRL_OFFSET, 32'(OP_WRITE_BYTE));
		// a write while busy must not disturb the byte being shifted out
		apb(1'b1, DATA_OFFSET, 32'h55);
		wait_idle();
		apb(1'b0, DATA_OFFSET, 32'h0);
		check("data after byte", rd, 32'h0);
		check("last write one low", last_run, WRITE1_LOW_US * US_CYCLES);
		check("device qualified", swire_device_model_i.active, 32'h1);
		apb(1'b1, CTRL_OFFSET, 32'(OP_TRIPLET));
		wait_idle();
		check("triplet bits", rd[4:2], {29'h0, ROM[0], !ROM[0], ROM[0]});
		check("device kept", swire_device_model_i.active, 32'h1);
		check("taken write low", last_run, WRITE1_LOW_US * US_CYCLES);
		// next search step of the model sends the second address bit
		apb(1'b1, CTRL_OFFSET, 32'(OP_READ_BIT));
		wait_idle();
		check("read low", last_run, READ_LOW_US * US_CYCLES);
		apb(1'b0, DATA_OFFSET, 32'h0);
		check("read bit", rd, {31'h0, ROM[1]});
		results();
	end
endmodule
